// *** src/mpc_pkg.sv ***
// constants and types of the memory paging control block
package mpc_pkg;
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_MISC = 8'h13;
    localparam logic [7:0] IDX_STRAP_VIEW = 8'h1D;
    localparam logic [7:0] IDX_PAGE = 8'h30;
    localparam logic [15:0] ADDR_BASE_INIT = 16'hFFFC;
    localparam int IDX_SHIFT = 2;

    // register block base field, 2K aligned
    localparam int BASE_LSB = 11;
    localparam int BASE_W = 5;
    localparam logic [4:0] BASE_RST = 5'h00;

    // strap view field positions
    localparam int ROM_SIZE_LSB = 6;
    localparam int SPLIT_LSB = 0;

    // misc control field positions and reset
    localparam int LO_ROM_DIS_BIT = 1;
    localparam int ROM_EN_BIT = 0;
    localparam logic [1:0] MISC_RST = 2'h1;

    // page index reset options
    localparam logic [5:0] PAGE_RST_ANY = 6'h00;
    localparam logic [5:0] PAGE_RST_SPECIAL = 6'h3C;

    // rom size strap codes
    localparam logic [1:0] ROM_NONE = 2'h0;
    localparam logic [1:0] ROM_16K = 2'h1;
    localparam logic [1:0] ROM_48K = 2'h2;
    localparam logic [1:0] ROM_64K = 2'h3;

    // first on-chip page per paging split code
    localparam logic [5:0] SPLIT0_FIRST = 6'h38;
    localparam logic [5:0] SPLIT1_FIRST = 6'h30;
    localparam logic [5:0] SPLIT2_FIRST = 6'h20;
    localparam logic [5:0] SPLIT3_FIRST = 6'h00;

    // cpu address regions
    localparam logic [1:0] REG_LOW_ROM = 2'h1;
    localparam logic [1:0] REG_WINDOW = 2'h2;
    localparam logic [1:0] REG_HIGH_ROM = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MPC_SRC_PERIPH = 3'h1,
        MPC_SRC_FLASH = 3'h2,
        MPC_SRC_EXT = 3'h4
    } mpc_src_t;
endpackage

// *** src/mpc_page_map.sv ***
// address decode and page window translation for the cpu bus
`timescale 1ns/1ps
module mpc_page_map (
    input wire logic [15:0] i_cpu_addr,
    input wire logic [5:0] i_page_index_bits,
    input wire logic [1:0] i_rom_size,
    input wire logic [1:0] i_split,
    input wire logic i_rom_enable,
    input wire logic i_lower_half_rom_disable,
    input wire logic [4:0] i_reg_base,
    output mpc_pkg::mpc_src_t o_src,
    output logic [19:0] o_ext_addr
);
    logic [5:0] first_onchip;
    logic in_window;
    logic onchip_page;
    logic big_rom;

    always_comb begin
        case (i_split)
            2'h0: first_onchip = mpc_pkg::SPLIT0_FIRST;
            2'h1: first_onchip = mpc_pkg::SPLIT1_FIRST;
            2'h2: first_onchip = mpc_pkg::SPLIT2_FIRST;
            default: first_onchip = mpc_pkg::SPLIT3_FIRST;
        endcase
    end

    assign in_window = (i_cpu_addr[15:14] == mpc_pkg::REG_WINDOW);
    assign onchip_page = (i_page_index_bits >= first_onchip);
    assign big_rom = (i_rom_size == mpc_pkg::ROM_48K) ||
                     (i_rom_size == mpc_pkg::ROM_64K);

    // registers outrank memory, memory outranks external space
    always_comb begin
        o_src = mpc_pkg::MPC_SRC_EXT;
        if (i_cpu_addr[15:mpc_pkg::BASE_LSB] == i_reg_base) begin
            o_src = mpc_pkg::MPC_SRC_PERIPH;
        end else if (!i_rom_enable || i_rom_size == mpc_pkg::ROM_NONE) begin
            o_src = mpc_pkg::MPC_SRC_EXT;
        end else if (in_window) begin
            if (onchip_page) begin
                o_src = mpc_pkg::MPC_SRC_FLASH;
            end
        end else if (i_cpu_addr[15:14] == mpc_pkg::REG_HIGH_ROM) begin
            o_src = mpc_pkg::MPC_SRC_FLASH;
        end else if (i_cpu_addr[15:14] == mpc_pkg::REG_LOW_ROM) begin
            // fixed lower pages stay reachable through the window
            if (big_rom && !i_lower_half_rom_disable) begin
                o_src = mpc_pkg::MPC_SRC_FLASH;
            end
        end
    end

    // window accesses carry the page number above the 16K offset
    always_comb begin
        if (in_window) begin
            o_ext_addr = {i_page_index_bits, i_cpu_addr[13:0]};
        end else begin
            o_ext_addr = {4'h0, i_cpu_addr};
        end
    end
endmodule

// *** src/mpc_top.sv ***
// memory paging control: strap view, page index and cpu bus steering
// Function
// - strap view sits at index 0x1D above the relocatable register base.
// - strap view returns live rom size and paging split strap levels.
// - strap view readable any time; writes to it change nothing.
// - strap view value after reset comes from the strap inputs.
// - bits 7:6 encode rom space none, 16K, 48K, 64K.
// - bits 1:0 encode off/on-chip split 896K/128K up to 0K/1M.
// - 48K and 64K rom accessibility decided by lower-half disable bit.
// - disable bit set blocks fixed lower rom; window still reaches it.
// - page index at index 0x30 above the base, readable any time.
// - six index bits map a 16K page into 0x8000 to 0xBFFF.
// - index n selects page n of 64 for window accesses.
// - page index resets to 0x00 or 0x3C per write permission option.
// - build parameter picks writes in all modes or special modes only.
// - bus write to page index takes effect one cycle later.
// - call and return side path reads and writes index off the bus.
// - side path update completes before the instruction ends.
// - several input data buses muxed onto the cpu read bus.
// - cpu address and write data steered onto outgoing buses.
// - byte lanes of cpu read data swapped as the cpu expects.
`timescale 1ns/1ps
module mpc_top #(
    parameter bit P_WRITE_SPECIAL_ONLY = 1'b0
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // axi4-lite slave
    input wire logic [15:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [15:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // integration straps and mode
    input wire logic i_rom_size_strap_hi,
    input wire logic i_rom_size_strap_lo,
    input wire logic i_paging_split_strap_hi,
    input wire logic i_paging_split_strap_lo,
    input wire logic i_special_mode,
    // call and return side path
    input wire logic i_call_page_wr,
    input wire logic [5:0] i_call_page_wdata,
    output logic [5:0] o_call_page_rdata,
    // cpu side
    input wire logic [15:0] i_cpu_addr,
    input wire logic [15:0] i_cpu_wdata,
    input wire logic i_cpu_rd,
    input wire logic i_cpu_wr,
    input wire logic i_cpu_byte,
    output logic [15:0] o_cpu_rdata,
    // source buses towards the core
    input wire logic [15:0] i_periph_rdata,
    input wire logic [15:0] i_flash_rdata,
    input wire logic [15:0] i_ext_rdata,
    // outgoing buses
    output logic [19:0] o_out_addr,
    output logic [15:0] o_out_wdata,
    output logic o_out_rd,
    output logic o_out_wr,
    output logic [2:0] o_out_sel,
    output logic [5:0] o_page_index_bits,
    output logic o_lower_half_rom_disable
);
    logic [4:0] base_q;
    logic [1:0] misc_q;
    logic misc_locked_q;
    logic [5:0] page_q;
    logic [15:0] aw_addr_q;
    logic aw_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_held_q;
    logic [1:0] bresp_q;
    logic bvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic rvalid_q;
    logic [15:0] cpu_rdata_q;
    logic [19:0] out_addr_q;
    logic [15:0] out_wdata_q;
    logic out_rd_q;
    logic out_wr_q;
    logic [2:0] out_sel_q;
    logic rd_byte_q;
    logic rd_odd_q;
    mpc_pkg::mpc_src_t rd_src_q;

    logic [1:0] rom_size;
    logic [1:0] split;
    logic [7:0] strap_view;
    logic [7:0] page_view;
    logic [7:0] misc_view;
    logic wr_fire;
    logic wr_base;
    logic wr_misc;
    logic wr_page;
    logic wr_hit;
    logic page_wr_ok;
    logic misc_wr_ok;
    logic [15:0] rd_data_w;
    logic rd_hit;
    logic [15:0] src_data;
    mpc_pkg::mpc_src_t cpu_src;
    logic [19:0] map_addr;

    localparam logic [5:0] PAGE_RST = P_WRITE_SPECIAL_ONLY ?
        mpc_pkg::PAGE_RST_SPECIAL : mpc_pkg::PAGE_RST_ANY;

    // strap view is combinational so it follows the pins from reset on
    assign rom_size = {i_rom_size_strap_hi, i_rom_size_strap_lo};
    assign split = {i_paging_split_strap_hi, i_paging_split_strap_lo};
    always_comb begin
        strap_view = 8'h00;
        strap_view[mpc_pkg::ROM_SIZE_LSB +: 2] = rom_size;
        strap_view[mpc_pkg::SPLIT_LSB +: 2] = split;
    end
    assign page_view = {2'h0, page_q};
    assign misc_view = {6'h00, misc_q};

    // register address match against the relocatable base
    function automatic logic at_idx(input logic [15:0] a,
                                    input logic [4:0] base,
                                    input logic [7:0] idx);
        logic [15:0] byte_addr;
        byte_addr = {base, 11'h000} +
                    {6'h00, idx, 2'h0};
        at_idx = (a == byte_addr);
    endfunction

    // write channel: address and data taken in either order
    assign o_awready = !aw_held_q;
    assign o_wready = !w_held_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign wr_base = wr_fire && (aw_addr_q == mpc_pkg::ADDR_BASE_INIT);
    assign wr_misc = wr_fire && !wr_base &&
                     at_idx(aw_addr_q, base_q, mpc_pkg::IDX_MISC);
    assign wr_page = wr_fire && !wr_base &&
                     at_idx(aw_addr_q, base_q, mpc_pkg::IDX_PAGE);
    // strap view address is mapped but the write is dropped
    assign wr_hit = wr_base || wr_misc || wr_page ||
                    at_idx(aw_addr_q, base_q, mpc_pkg::IDX_STRAP_VIEW);
    assign page_wr_ok = !P_WRITE_SPECIAL_ONLY || i_special_mode;
    assign misc_wr_ok = i_special_mode || !misc_locked_q;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 16'h0000;
        end else if (i_awvalid && !aw_held_q) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= i_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (i_wvalid && !w_held_q) begin
            w_held_q <= 1'b1;
            w_data_q <= i_wdata;
            w_strb_q <= i_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bvalid_q <= 1'b0;
            bresp_q <= mpc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? mpc_pkg::RESP_OKAY : mpc_pkg::RESP_SLVERR;
        end else if (i_bready) begin
            bvalid_q <= 1'b0;
        end
    end
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;

    // register block base, moves every indexed register with it
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            base_q <= mpc_pkg::BASE_RST;
        end else if (wr_base && w_strb_q[1]) begin
            base_q <= w_data_q[mpc_pkg::BASE_LSB +: mpc_pkg::BASE_W];
        end
    end

    // misc control: write once in normal modes, any time in special
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            misc_q <= mpc_pkg::MISC_RST;
            misc_locked_q <= 1'b0;
        end else if (wr_misc && w_strb_q[0] && misc_wr_ok) begin
            misc_q <= w_data_q[1:0];
            misc_locked_q <= 1'b1;
        end
    end
    assign o_lower_half_rom_disable = misc_q[mpc_pkg::LO_ROM_DIS_BIT];

    // side path wins a clash: the instruction must finish its update
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            page_q <= PAGE_RST;
        end else if (i_call_page_wr) begin
            page_q <= i_call_page_wdata;
        end else if (wr_page && w_strb_q[0] && page_wr_ok) begin
            page_q <= w_data_q[5:0];
        end
    end
    assign o_call_page_rdata = page_q;
    assign o_page_index_bits = page_q;

    // read channel, one outstanding read, answer the cycle after
    always_comb begin
        rd_hit = 1'b1;
        rd_data_w = 16'h0000;
        if (i_araddr == mpc_pkg::ADDR_BASE_INIT) begin
            rd_data_w = {base_q, 11'h000};
        end else if (at_idx(i_araddr, base_q, mpc_pkg::IDX_STRAP_VIEW)) begin
            rd_data_w = {8'h00, strap_view};
        end else if (at_idx(i_araddr, base_q, mpc_pkg::IDX_PAGE)) begin
            rd_data_w = {8'h00, page_view};
        end else if (at_idx(i_araddr, base_q, mpc_pkg::IDX_MISC)) begin
            rd_data_w = {8'h00, misc_view};
        end else begin
            rd_hit = 1'b0;
        end
    end
    assign o_arready = !rvalid_q;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= mpc_pkg::RESP_OKAY;
        end else if (i_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_data_w};
            rresp_q <= rd_hit ? mpc_pkg::RESP_OKAY : mpc_pkg::RESP_SLVERR;
        end else if (i_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;

    mpc_page_map u_map (
        .i_cpu_addr(i_cpu_addr),
        .i_page_index_bits(page_q),
        .i_rom_size(rom_size),
        .i_split(split),
        .i_rom_enable(misc_q[mpc_pkg::ROM_EN_BIT]),
        .i_lower_half_rom_disable(misc_q[mpc_pkg::LO_ROM_DIS_BIT]),
        .i_reg_base(base_q),
        .o_src(cpu_src),
        .o_ext_addr(map_addr)
    );

    // outgoing address and write data, registered one cycle
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            out_addr_q <= 20'h00000;
            out_wdata_q <= 16'h0000;
            out_rd_q <= 1'b0;
            out_wr_q <= 1'b0;
            out_sel_q <= 3'h0;
        end else begin
            out_addr_q <= map_addr;
            out_rd_q <= i_cpu_rd;
            out_wr_q <= i_cpu_wr;
            out_sel_q <= (i_cpu_rd || i_cpu_wr) ? cpu_src : 3'h0;
            // a byte write is copied onto both lanes
            if (i_cpu_byte) begin
                out_wdata_q <= {i_cpu_wdata[7:0], i_cpu_wdata[7:0]};
            end else begin
                out_wdata_q <= i_cpu_wdata;
            end
        end
    end
    assign o_out_addr = out_addr_q;
    assign o_out_wdata = out_wdata_q;
    assign o_out_rd = out_rd_q;
    assign o_out_wr = out_wr_q;
    assign o_out_sel = out_sel_q;

    // read steering: sources answer one cycle after the request
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_src_q <= mpc_pkg::MPC_SRC_EXT;
            rd_byte_q <= 1'b0;
            rd_odd_q <= 1'b0;
        end else if (i_cpu_rd) begin
            rd_src_q <= cpu_src;
            rd_byte_q <= i_cpu_byte;
            rd_odd_q <= i_cpu_addr[0];
        end
    end

    always_comb begin
        case (rd_src_q)
            mpc_pkg::MPC_SRC_PERIPH: src_data = i_periph_rdata;
            mpc_pkg::MPC_SRC_FLASH: src_data = i_flash_rdata;
            default: src_data = i_ext_rdata;
        endcase
    end

    // big-endian bus: an even byte arrives in the high lane
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cpu_rdata_q <= 16'h0000;
        end else if (rd_byte_q && !rd_odd_q) begin
            cpu_rdata_q <= {8'h00, src_data[15:8]};
        end else if (rd_byte_q) begin
            cpu_rdata_q <= {8'h00, src_data[7:0]};
        end else begin
            cpu_rdata_q <= src_data;
        end
    end
    assign o_cpu_rdata = cpu_rdata_q;
endmodule

// *** test/mpc_src_model.sv ***
// source bus model standing in for peripheral, flash and external memory
`timescale 1ns/1ps
module mpc_src_model (
    input wire logic i_sys_clk,
    input wire logic [2:0] i_sel,
    input wire logic [19:0] i_addr,
    output logic [15:0] o_periph,
    output logic [15:0] o_flash,
    output logic [15:0] o_ext
);
    logic [15:0] junk_q = 16'h0;
    // idle sources move every cycle so a stale word never passes
    always_ff @(posedge i_sys_clk) begin
        junk_q <= junk_q + 16'h3B1D;
    end
    assign o_periph = i_sel[0] ? i_addr[15:0] ^ 16'hA500 : junk_q;
    assign o_flash = i_sel[1] ? i_addr[15:0] ^ 16'h5A00 : ~junk_q;
    assign o_ext = i_sel[2] ? i_addr[15:0] ^ 16'hC300 : junk_q;
endmodule

// *** test/mpc_top_assertions.sv ***
// concurrent checks on the memory paging control ports
`timescale 1ns/1ps
module mpc_top_checker (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic [1:0] o_bresp,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic [1:0] o_rresp,
    input wire logic [31:0] o_rdata,
    input wire logic i_rready,
    input wire logic i_call_page_wr,
    input wire logic [5:0] i_call_page_wdata,
    input wire logic [5:0] o_call_page_rdata,
    input wire logic [5:0] o_page_index_bits,
    input wire logic [15:0] i_cpu_addr,
    input wire logic i_cpu_rd,
    input wire logic i_cpu_byte,
    input wire logic [15:0] i_flash_rdata,
    input wire logic [19:0] o_out_addr,
    input wire logic o_out_rd,
    input wire logic [2:0] o_out_sel,
    input wire logic [15:0] o_cpu_rdata
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    bresp_hold_a: assert property (o_bvalid && !i_bready |=>
        o_bvalid && $stable(o_bresp)) else $error("bresp dropped");
    rdata_hold_a: assert property (o_rvalid && !i_rready |=>
        o_rvalid && $stable(o_rdata)) else $error("rdata dropped");
    read_answer_a: assert property (i_arvalid && o_arready |=>
        o_rvalid) else $error("no read answer");
    write_answer_a: assert property (i_awvalid && o_awready &&
        i_wvalid && o_wready |=> ##[0:1] o_bvalid)
        else $error("no write answer");
    err_zero_a: assert property (o_rvalid &&
        o_rresp == mpc_pkg::RESP_SLVERR |-> o_rdata == 32'h0)
        else $error("error read data not zero");
    side_load_a: assert property (i_call_page_wr |=>
        o_page_index_bits == $past(i_call_page_wdata))
        else $error("side path load missed");
    page_move_a: assert property ($changed(o_call_page_rdata) |->
        $past(i_call_page_wr) || $rose(o_bvalid))
        else $error("page moved without a write");
    out_addr_a: assert property (i_cpu_rd |=> o_out_rd &&
        o_out_addr[13:0] == $past(i_cpu_addr[13:0]))
        else $error("outgoing address wrong");
    win_page_a: assert property (i_cpu_rd &&
        i_cpu_addr[15:14] == 2'h2 |=>
        o_out_addr[19:14] == $past(o_page_index_bits))
        else $error("window page wrong");
    flash_data_a: assert property ($past(i_cpu_rd, 2) &&
        !$past(i_cpu_byte, 2) &&
        $past(o_out_sel) == mpc_pkg::MPC_SRC_FLASH |->
        o_cpu_rdata == $past(i_flash_rdata))
        else $error("flash read data wrong");
    cover property (o_bvalid && i_bready);
    cover property (i_call_page_wr);
    cover property (o_out_rd && o_out_sel == mpc_pkg::MPC_SRC_EXT);
endmodule
bind mpc_top mpc_top_checker u_mpc_top_checker (.*);

// *** test/memory_paging_control_bench.sv ***
// register and cpu path tests of the memory paging control block
`timescale 1ns/1ps
module memory_paging_control_bench;
    logic i_sys_clk = 1'h0, i_nrst = 1'h0, i_awvalid = 1'h0;
    logic i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0;
    logic i_rready = 1'h0, i_special_mode = 1'h0, i_call_page_wr = 1'h0;
    logic i_rom_size_strap_hi = 1'h0, i_rom_size_strap_lo = 1'h1;
    logic i_paging_split_strap_hi = 1'h1, i_paging_split_strap_lo = 1'h1;
    logic i_cpu_rd = 1'h0, i_cpu_wr = 1'h0, i_cpu_byte = 1'h0;
    logic [15:0] i_awaddr = 16'h0, i_araddr = 16'h0, i_cpu_addr = 16'h0;
    logic [15:0] i_cpu_wdata = 16'h0;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0] i_wstrb = 4'h0;
    logic [5:0] i_call_page_wdata = 6'h0;
    logic [15:0] i_periph_rdata, i_flash_rdata, i_ext_rdata;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic o_out_rd, o_out_wr, o_lower_half_rom_disable;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata, rd;
    logic [5:0] o_call_page_rdata, o_page_index_bits, pg_b;
    logic [15:0] o_cpu_rdata, o_out_wdata;
    logic [19:0] o_out_addr;
    logic [2:0] o_out_sel;
    logic [1:0] rr;
    int num_errors = 0, compares = 0;
    localparam logic [2:0] FL = 3'h2, EX = 3'h4, PE = 3'h1;
    localparam logic [1:0] OK = 2'h0, ERR = 2'h2;

    always #2 i_sys_clk = ~i_sys_clk;
    mpc_top u_mpc_top (.*);
    // second build option shares every input, only its page is watched
    mpc_top #(.P_WRITE_SPECIAL_ONLY(1'h1)) u_mpc_top_spc (.*,
        .o_awready(), .o_wready(), .o_bresp(), .o_bvalid(),
        .o_arready(), .o_rdata(), .o_rresp(), .o_rvalid(),
        .o_call_page_rdata(), .o_cpu_rdata(), .o_out_addr(),
        .o_out_wdata(), .o_out_rd(), .o_out_wr(), .o_out_sel(),
        .o_page_index_bits(pg_b), .o_lower_half_rom_disable());
    mpc_src_model u_mpc_src_model (.i_sys_clk(i_sys_clk),
        .i_sel(o_out_sel), .i_addr(o_out_addr), .o_periph(i_periph_rdata),
        .o_flash(i_flash_rdata), .o_ext(i_ext_rdata));

    task give_verdict;
        $display("counts: %0d compares, %0d errors", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task check_word(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task bail(input string n);
        num_errors++;
        $display("mismatch %s expected done seen timeout", n);
        give_verdict();
    endtask
    task axi_wr(input logic [15:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] er);
        int n;
        logic aw, w, b, ta, tw, tb;
        logic [1:0] rb;
        @(posedge i_sys_clk);
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= s;
        i_awvalid <= 1'h1;
        i_wvalid <= 1'h1;
        i_bready <= 1'h1;
        {aw, w, b} = 3'h7;
        n = 0;
        while (b && n < 40) begin
            #1;
            ta = aw && o_awready;
            tw = w && o_wready;
            tb = o_bvalid;
            rb = o_bresp;
            @(posedge i_sys_clk);
            if (ta) begin
                i_awvalid <= 1'h0;
                aw = 1'h0;
            end
            if (tw) begin
                i_wvalid <= 1'h0;
                w = 1'h0;
            end
            if (tb) b = 1'h0;
            n++;
        end
        i_bready <= 1'h0;
        if (b) bail("write");
        check_word("bresp", 32'(er), 32'(rb));
    endtask
    task rd_chk(input logic [15:0] a, input logic [31:0] e,
        input logic [1:0] er);
        int n;
        logic ar, ta, tb;
        @(posedge i_sys_clk);
        i_araddr <= a;
        i_arvalid <= 1'h1;
        i_rready <= 1'h1;
        ar = 1'h1;
        tb = 1'h0;
        n = 0;
        while (!tb && n < 40) begin
            #1;
            ta = ar && o_arready;
            tb = o_rvalid;
            rd = o_rdata;
            rr = o_rresp;
            @(posedge i_sys_clk);
            if (ta) begin
                i_arvalid <= 1'h0;
                ar = 1'h0;
            end
            n++;
        end
        i_rready <= 1'h0;
        if (!tb) bail("read");
        check_word("rdata", e, rd);
        check_word("rresp", 32'(er), 32'(rr));
    endtask
    // request in one cycle, routing after one edge, data after the next
    task cpu_chk(input logic [15:0] a, input logic bm,
        input logic [2:0] es, input logic [19:0] ea);
        logic [15:0] w;
        w = ea[15:0] ^ (es == FL ? 16'h5A00 : es == EX ? 16'hC300 : 16'hA500);
        if (bm) w = {8'h00, a[0] ? w[7:0] : w[15:8]};
        @(posedge i_sys_clk);
        i_cpu_addr <= a;
        i_cpu_byte <= bm;
        i_cpu_rd <= 1'h1;
        @(posedge i_sys_clk);
        i_cpu_rd <= 1'h0;
        i_cpu_byte <= 1'h0;
        #1;
        check_word("out_sel", 32'(es), 32'(o_out_sel));
        check_word("out_addr", 32'(ea), 32'(o_out_addr));
        @(posedge i_sys_clk);
        #1;
        check_word("cpu_rdata", 32'(w), 32'(o_cpu_rdata));
    endtask
    task set_straps(input logic [1:0] rom, input logic [1:0] split);
        @(posedge i_sys_clk);
        {i_rom_size_strap_hi, i_rom_size_strap_lo} <= rom;
        {i_paging_split_strap_hi, i_paging_split_strap_lo} <= split;
    endtask

    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_nrst <= 1'h1;
        #1;
        check_word("page", 32'(mpc_pkg::PAGE_RST_ANY),
            32'(o_page_index_bits));
        check_word("page_b", 32'(mpc_pkg::PAGE_RST_SPECIAL), 32'(pg_b));
        rd_chk(16'h0074, 32'h43, OK);
        rd_chk(16'h00C0, 32'h0, OK);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            set_straps(2'(k), 2'(3 - k));
            rd_chk(16'h0074, 32'({2'(k), 4'h0, 2'(3 - k)}),
                OK);
        end
        axi_wr(16'h0074, 32'hFF, 4'hF, OK);
        rd_chk(16'h0074, 32'hC0, OK);
        $display("test strap view done");
        axi_wr(16'h00C0, 32'hFFFFFFFF, 4'hF, OK);
        #1;
        check_word("page", 32'h3F, 32'(o_page_index_bits));
        check_word("page_b", 32'h3C, 32'(pg_b));
        rd_chk(16'h00C0, 32'h3F, OK);
        i_special_mode <= 1'h1;
        axi_wr(16'h00C0, 32'h05, 4'h1, OK);
        #1;
        check_word("page_b", 32'h05, 32'(pg_b));
        @(posedge i_sys_clk);
        i_special_mode <= 1'h0;
        i_call_page_wr <= 1'h1;
        i_call_page_wdata <= 6'h2A;
        @(posedge i_sys_clk);
        i_call_page_wr <= 1'h0;
        #1;
        check_word("page", 32'h2A, 32'(o_page_index_bits));
        check_word("call_page", 32'h2A, 32'(o_call_page_rdata));
        rd_chk(16'h00C0, 32'h2A, OK);
        axi_wr(16'h00C0, 32'h05, 4'h1, OK);
        #1;
        check_word("page", 32'h05, 32'(o_page_index_bits));
        check_word("page_b", 32'h2A, 32'(pg_b));
        $display("test page index done");
        set_straps(2'h2, 2'h3);
        cpu_chk(16'h8124, 1'h0, FL, 20'h14124);
        cpu_chk(16'h8124, 1'h1, FL, 20'h14124);
        cpu_chk(16'h8125, 1'h1, FL, 20'h14125);
        cpu_chk(16'hC010, 1'h0, FL, 20'h0C010);
        cpu_chk(16'h4010, 1'h0, FL, 20'h04010);
        @(posedge i_sys_clk);
        i_cpu_wr <= 1'h1;
        i_cpu_byte <= 1'h1;
        i_cpu_wdata <= 16'h12A7;
        @(posedge i_sys_clk);
        i_cpu_wr <= 1'h0;
        i_cpu_byte <= 1'h0;
        #1;
        check_word("out_wdata", 32'hA7A7, 32'(o_out_wdata));
        check_word("out_wr", 32'h1, 32'(o_out_wr));
        axi_wr(16'h004C, 32'h03, 4'h1, OK);
        #1;
        check_word("lo_dis", 32'h1, 32'(o_lower_half_rom_disable));
        cpu_chk(16'h4010, 1'h0, EX, 20'h04010);
        cpu_chk(16'h8124, 1'h0, FL, 20'h14124);
        set_straps(2'h2, 2'h0);
        cpu_chk(16'h8124, 1'h0, EX, 20'h14124);
        set_straps(2'h0, 2'h3);
        cpu_chk(16'hC010, 1'h0, EX, 20'h0C010);
        $display("test cpu path done");
        rd_chk(16'h0100, 32'h0, ERR);
        axi_wr(16'h0100, 32'h05, 4'hF, ERR);
        axi_wr(16'hFFFC, 32'h0800, 4'h3, OK);
        rd_chk(16'h0874, 32'h03, OK);
        rd_chk(16'h08C0, 32'h05, OK);
        rd_chk(16'h00C0, 32'h0, ERR);
        cpu_chk(16'h0812, 1'h0, PE, 20'h00812);
        $display("test relocation done");
        give_verdict();
    end
endmodule
